// *** rtl/led_ctrl_pkg.sv ***
// Package with constants and carrier types for the LED string controller.
package led_ctrl_pkg;
  localparam int unsigned STRINGS = 4;
  // Enable-low shutdown limit in internal clock cycles.
  localparam int unsigned SHUTDOWN_LIMIT_CYCLES = 131072;
  // Supply-low filter time and its cycle count at 250 MHz.
  localparam int unsigned UV_FILTER_NS = 50000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned UV_FILTER_CYCLES = UV_FILTER_NS / CLK_PERIOD_NS;
  // Sink current gain and divisors; boost and disconnect limits in mA.
  localparam int unsigned CURRENT_GAIN = 960;
  localparam logic [7:0] SOFT_SINK_DIVISOR = 8'h14;
  localparam logic [7:0] QUARTER_DIVISOR = 8'h04;
  localparam logic [7:0] FULL_DIVISOR = 8'h01;
  localparam logic [15:0] SOFT_BOOST_LIMIT_MA = 16'h0258;
  localparam logic [15:0] NORMAL_BOOST_LIMIT_MA = 16'h0e10;
  localparam logic [15:0] DISCONNECT_TRIP_MA = 16'h0546;
  localparam logic [3:0] LOCKOUT_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_SHUTDOWN = 2'b00,
    ST_SOFT = 2'b01,
    ST_RUN = 2'b10,
    ST_LATCHED = 2'b11
  } mode_e;

  // Raw comparator results from the analog front end.
  typedef struct packed {
    logic ovp_high;
    logic ovp_low;
    logic [3:0] sink_short;
    logic [3:0] sink_in_reg;
    logic [3:0] sink_above_soft;
    logic switch_overvolt;
    logic disconnect_overcurrent;
    logic supply_above_hys;
    logic supply_below_th;
  } comp_s;

  // Drive settings to the analog power stage.
  typedef struct packed {
    logic boost_on;
    logic comp_float;
    logic [15:0] boost_limit_ma;
    logic [3:0] sink_on;
    logic [7:0] sink_divisor;
    logic [3:0] loop_member;
  } drive_s;
endpackage

// *** rtl/led_string_driver_fault_control.sv ***
// Control, dimming and fault latching logic of the four-string LED driver.
`timescale 1ns/10ps
// Behaviour
// R1: Select bits choose strings: 1, 1-2, 1-3 or all four.
// R2: Unselected connected string above short threshold still trips short shutdown.
// R3: Startup soft-start limits boost to 0.6 A, sinks 1/20 until settled.
// R4: Leaving soft-start restores normal boost limit and full sink current.
// R5: After settling, enabled sinks follow the enable PWM between zero and full.
// R6: Full-scale sink current is reference current times gain 960.
// R7: Enable high turns device on and sinks draw full scale.
// R8: Enable low stops boost and sinks, floats compensation, keeps core alive.
// R9: Enable low beyond limit causes shutdown and clears all fault state.
// R10: Shutdown limit is enable low for more than 131072 clock cycles.
// R11: Host should dim enable at 100 to 300 Hz.
// R12: Dim select low gives full current, high gives quarter current.
// R13: Overvoltage locks out-of-regulation strings out of the feedback loop.
// R14: Every overvoltage event re-evaluates lockout of all strings.
// R15: Enable low shorter than shutdown limit keeps lockout state.
// R16: Locked-out sinks still draw set current; only loop membership changes.
// R17: Any sink above short threshold latches everything off until shutdown.
// R18: Overvoltage flag sets above 200 uA and releases below 165 uA.
// R19: Switch-node overvoltage latches device off until shutdown.
// R20: Boost switch current limited cycle by cycle at 3.6 A.
// R21: Disconnect overcurrent at 1.35 A disables the device.
// R22: Supply lockout releases above hysteresis, trips after 50 us below.
// R23: All comparator results are synchronised before use.
module led_string_driver_fault_control
  import led_ctrl_pkg::*;
#(
  parameter int unsigned SHUTDOWN_CYCLES = SHUTDOWN_LIMIT_CYCLES,
  parameter int unsigned UV_CYCLES = UV_FILTER_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic string_select_bit0_i,
  input wire logic string_select_bit1_i,
  input wire logic quarter_level_select_i,
  input wire comp_s comp_i,
  output drive_s drive_o,
  output logic [3:0] lockout_o,
  output logic fault_latched_o,
  output logic ovp_flag_o,
  output logic supply_ok_o,
  output mode_e mode_o
);

  localparam int unsigned CW = 18;
  localparam int unsigned UW = 16;

  comp_s sync1_q;
  comp_s sync2_q;
  logic [3:0] enabled_strings;
  logic ovp_q;
  logic ovp_prev_q;
  logic ovp_rise;
  logic [CW-1:0] low_cnt_q;
  logic shutdown_q;
  logic [UW-1:0] uv_cnt_q;
  logic supply_ok_q;
  logic [3:0] lockout_q;
  logic short_q;
  logic node_overvolt_q;
  logic oc_q;
  logic any_fault;
  mode_e mode_q;
  mode_e mode_d;
  drive_s drive_q;
  drive_s drive_d;

  // Two-stage synchroniser; only the second stage is looked at.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= comp_i; // see R23
      sync2_q <= sync1_q;
    end
  end

  // Select decode: bit0 alone adds string 2, bit1 alone adds strings 2 and 3, both add 2 to 4.
  always_comb
  begin
    case ({string_select_bit1_i, string_select_bit0_i}) // see R1
      2'b00: enabled_strings = 4'b0001;
      2'b01: enabled_strings = 4'b0011;
      2'b10: enabled_strings = 4'b0111;
      default: enabled_strings = 4'b1111;
    endcase
  end

  // Overvoltage flag with hysteresis from the two current comparators.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ovp_q <= 1'b0;
      ovp_prev_q <= 1'b0;
    end
    else
    begin
      if (sync2_q.ovp_high)
        ovp_q <= 1'b1; // see R18
      else if (sync2_q.ovp_low)
        ovp_q <= 1'b0; // see R18
      ovp_prev_q <= ovp_q;
    end
  end
  assign ovp_rise = ovp_q && !ovp_prev_q;

  // Enable-low timer; saturates so a long low keeps shutdown asserted.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      low_cnt_q <= '0;
      shutdown_q <= 1'b1;
    end
    else if (enable_i)
    begin
      low_cnt_q <= '0;
      shutdown_q <= 1'b0;
    end
    else if (low_cnt_q < CW'(SHUTDOWN_CYCLES))
      low_cnt_q <= low_cnt_q + 1'b1;
    else
      shutdown_q <= 1'b1; // see R9 see R10
  end

  // Supply lockout: quick release, slow filtered trip against glitches.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      uv_cnt_q <= '0;
      supply_ok_q <= 1'b0;
    end
    else if (!supply_ok_q)
    begin
      uv_cnt_q <= '0;
      if (sync2_q.supply_above_hys)
        supply_ok_q <= 1'b1; // see R22
    end
    else if (!sync2_q.supply_below_th)
      uv_cnt_q <= '0;
    else if (uv_cnt_q < UW'(UV_CYCLES))
      uv_cnt_q <= uv_cnt_q + 1'b1;
    else
      supply_ok_q <= 1'b0; // see R22
  end

  // Loop lockout: each overvoltage edge retests every string.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      lockout_q <= LOCKOUT_RESET;
    else if (shutdown_q)
      lockout_q <= LOCKOUT_RESET; // see R9 see R15
    else if (ovp_rise)
      lockout_q <= enabled_strings & ~sync2_q.sink_in_reg; // see R13 see R14
  end

  // Fault latches; shutdown clears them and wins over any detect in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      short_q <= 1'b0;
      node_overvolt_q <= 1'b0;
      oc_q <= 1'b0;
    end
    else if (shutdown_q)
    begin
      short_q <= 1'b0; // see R9
      node_overvolt_q <= 1'b0;
      oc_q <= 1'b0;
    end
    else
    begin
      // Every sink pin is checked, selected or not.
      if (|sync2_q.sink_short)
        short_q <= 1'b1; // see R2 see R17
      if (sync2_q.switch_overvolt)
        node_overvolt_q <= 1'b1; // see R19
      if (sync2_q.disconnect_overcurrent)
        oc_q <= 1'b1; // see R21
    end
  end
  assign any_fault = short_q || node_overvolt_q || oc_q;

  // Mode sequencing: shutdown, soft-start, run, latched off.
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      ST_SHUTDOWN:
        if (!shutdown_q && enable_i && supply_ok_q)
          mode_d = ST_SOFT; // see R3
      ST_SOFT:
        if (((sync2_q.sink_above_soft & enabled_strings) == enabled_strings))
          mode_d = ST_RUN; // see R4
      ST_RUN:
        mode_d = ST_RUN;
      ST_LATCHED:
        mode_d = ST_LATCHED;
      default:
        mode_d = ST_SHUTDOWN;
    endcase
    if (any_fault)
      mode_d = ST_LATCHED;
    if (shutdown_q || !supply_ok_q)
      mode_d = ST_SHUTDOWN; // see R9 see R22
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      mode_q <= ST_SHUTDOWN;
    else
      mode_q <= mode_d;
  end

  // Power stage drive. Gain of 960 lives in the analog mirror; logic picks
  // the divisor. Registered so the drive never glitches on comparator noise.
  always_comb
  begin
    drive_d = '0;
    drive_d.boost_limit_ma = NORMAL_BOOST_LIMIT_MA; // see R20
    drive_d.sink_divisor = quarter_level_select_i ? QUARTER_DIVISOR
                                                  : FULL_DIVISOR; // see R12 see R6
    drive_d.loop_member = enabled_strings & ~lockout_q;
    drive_d.comp_float = !enable_i; // see R8
    if ((mode_q == ST_SOFT || mode_q == ST_RUN) && enable_i)
    begin
      drive_d.boost_on = 1'b1; // see R7 see R5
      // Locked strings keep sinking; only loop membership drops them.
      drive_d.sink_on = enabled_strings; // see R16
    end
    if (mode_q == ST_SOFT)
    begin
      drive_d.boost_limit_ma = SOFT_BOOST_LIMIT_MA; // see R3
      drive_d.sink_divisor = SOFT_SINK_DIVISOR;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      drive_q <= '0;
    else
      drive_q <= drive_d;
  end

  assign drive_o = drive_q;
  assign lockout_o = lockout_q;
  assign fault_latched_o = any_fault;
  assign ovp_flag_o = ovp_q;
  assign supply_ok_o = supply_ok_q;
  assign mode_o = mode_q;

  // Checks on the control behaviour. Most look one edge ahead, since the
  // drive word and the latches are all registered.
  a_select_decode: assert property ( // see R1
    @(posedge clk_i) disable iff (rst_i)
    enabled_strings == {string_select_bit0_i && string_select_bit1_i,
      string_select_bit1_i, string_select_bit0_i || string_select_bit1_i,
      1'b1})
    else $error("select decode wrong");
  // A supply trip or a shutdown in the same window may pre-empt the latch.
  a_short_latch: assert property ( // see R2 see R17
    @(posedge clk_i) disable iff (rst_i)
    (|sync2_q.sink_short) && !shutdown_q |=> short_q ##1
      (mode_q == ST_LATCHED || $past(shutdown_q) || !$past(supply_ok_q)))
    else $error("short did not latch");
  a_latched_no_drive: assert property ( // see R19
    @(posedge clk_i) disable iff (rst_i)
    mode_q == ST_LATCHED |=> !drive_q.boost_on && drive_q.sink_on == 4'h0)
    else $error("drive on while latched");
  a_soft_limit: assert property ( // see R3
    @(posedge clk_i) disable iff (rst_i)
    mode_q == ST_SOFT |=> drive_q.boost_limit_ma == SOFT_BOOST_LIMIT_MA
      && drive_q.sink_divisor == SOFT_SINK_DIVISOR)
    else $error("soft-start limits missing");
  a_run_limit: assert property ( // see R4
    @(posedge clk_i) disable iff (rst_i)
    mode_q == ST_RUN && !quarter_level_select_i |=>
      drive_q.boost_limit_ma == NORMAL_BOOST_LIMIT_MA
      && drive_q.sink_divisor == FULL_DIVISOR)
    else $error("normal limits not restored");
  a_enable_low_off: assert property ( // see R8
    @(posedge clk_i) disable iff (rst_i)
    !enable_i |=> !drive_q.boost_on && drive_q.comp_float
      && drive_q.sink_on == 4'h0)
    else $error("enable low did not stop");
  // Locked strings are not masked here: they must keep sinking.
  a_enable_high_on: assert property ( // see R7 see R16
    @(posedge clk_i) disable iff (rst_i)
    mode_q == ST_RUN && enable_i |=> drive_q.boost_on
      && drive_q.sink_on == $past(enabled_strings))
    else $error("enable high did not drive sinks");
  a_lockout_hold: assert property ( // see R15
    @(posedge clk_i) disable iff (rst_i)
    !ovp_rise && !shutdown_q |=> $stable(lockout_q))
    else $error("lockout changed without event");
  a_lockout_retest: assert property ( // see R13 see R14
    @(posedge clk_i) disable iff (rst_i)
    ovp_rise && !shutdown_q |=>
      lockout_q == ($past(enabled_strings) & ~$past(sync2_q.sink_in_reg)))
    else $error("lockout not retested");
  a_loop_excludes_locked: assert property ( // see R13
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (drive_q.loop_member & $past(lockout_q)) == 4'h0)
    else $error("locked string still in loop");
  a_shutdown_clear: assert property ( // see R9
    @(posedge clk_i) disable iff (rst_i)
    shutdown_q |=> lockout_q == 4'h0 && !any_fault)
    else $error("shutdown did not clear faults");
  // Shutdown must neither come early nor be missed at the limit.
  a_shutdown_timing: assert property ( // see R10
    @(posedge clk_i) disable iff (rst_i)
    !enable_i && !shutdown_q |=>
      shutdown_q == ($past(low_cnt_q) == CW'(SHUTDOWN_CYCLES)))
    else $error("shutdown limit wrong");
  a_fault_latches: assert property ( // see R19 see R21
    @(posedge clk_i) disable iff (rst_i)
    !shutdown_q && (sync2_q.switch_overvolt || sync2_q.disconnect_overcurrent)
      |=> any_fault)
    else $error("fault did not latch");
  a_supply_filter: assert property ( // see R22
    @(posedge clk_i) disable iff (rst_i)
    supply_ok_q && !sync2_q.supply_below_th |=> supply_ok_q)
    else $error("supply lockout tripped without a low supply");
  a_ovp_hyst: assert property ( // see R18
    @(posedge clk_i) disable iff (rst_i)
    ovp_q && !sync2_q.ovp_low |=> ovp_q)
    else $error("overvoltage flag released early");
  a_quarter_dim: assert property ( // see R12
    @(posedge clk_i) disable iff (rst_i)
    mode_q == ST_RUN && quarter_level_select_i |=>
      drive_q.sink_divisor == QUARTER_DIVISOR)
    else $error("quarter level not applied");

  c_run_reached: cover property (@(posedge clk_i) disable iff (rst_i)
    mode_q == ST_SOFT ##1 mode_q == ST_RUN);
  c_lockout_event: cover property (@(posedge clk_i) disable iff (rst_i)
    ovp_rise && lockout_q != 4'h0);
  c_latched: cover property (@(posedge clk_i) disable iff (rst_i)
    mode_q == ST_LATCHED);
  c_supply_trip: cover property (@(posedge clk_i) disable iff (rst_i)
    supply_ok_q ##1 !supply_ok_q);

endmodule // led_string_driver_fault_control

// *** bench/host_pins_model.sv ***
// Host model that drives the enable, string select and dim pins.
`timescale 1ns/10ps
module host_pins_model (
  input wire logic clk_i,
  output logic enable_o,
  output logic [1:0] select_o,
  output logic quarter_o
);
  // Pins start idle so the device stays in shutdown.
  initial
  begin
    enable_o = 1'b0;
    select_o = 2'h0;
    quarter_o = 1'b0;
  end

  // Pins change only on the falling edge, away from the sampling edge.
  task automatic set(input logic [1:0] s, input logic d);
    @(negedge clk_i);
    select_o = s;
    quarter_o = d;
  endtask

  // Holds enable at one level; dimming runs in short bursts.
  task automatic level(input logic en, input int n);
    @(negedge clk_i);
    enable_o = en;
    repeat (n) @(negedge clk_i);
  endtask
endmodule // host_pins_model

// *** bench/led_string_driver_fault_control_tb.sv ***
// Self-checking testbench of the LED string controller.
`timescale 1ns/10ps
module led_string_driver_fault_control_tb;
  import led_ctrl_pkg::*;
  typedef struct {int k; logic [15:0] v;} note_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  comp_s comp_i;
  drive_s drive_o;
  logic [3:0] lockout_o;
  logic fault_latched_o;
  logic ovp_flag_o;
  logic supply_ok_o;
  mode_e mode_o;
  logic enable;
  logic quarter;
  logic [1:0] sel;
  note_s q[$];
  note_s n;
  logic [15:0] obs;
  int fails = 0;
  int comparisons = 0;
  int seed = 32;
  logic [3:0] inreg;
  logic [3:0] mask [4] = '{4'h1, 4'h3, 4'h7, 4'hf};

  always #2 clk_i = ~clk_i;

  host_pins_model host (.clk_i(clk_i), .enable_o(enable), .select_o(sel),
    .quarter_o(quarter));

  // Short counts keep the run brief; expectations follow them.
  led_string_driver_fault_control #(.SHUTDOWN_CYCLES(16), .UV_CYCLES(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .enable_i(enable),
    .string_select_bit0_i(sel[0]), .string_select_bit1_i(sel[1]),
    .quarter_level_select_i(quarter), .comp_i(comp_i), .drive_o(drive_o),
    .lockout_o(lockout_o), .fault_latched_o(fault_latched_o),
    .ovp_flag_o(ovp_flag_o), .supply_ok_o(supply_ok_o), .mode_o(mode_o));

  task automatic note_v(input int k, input logic [15:0] v);
    q.push_back('{k, v});
  endtask

  // Notes are judged just after the falling edge, when outputs are settled.
  always @(negedge clk_i)
  begin
    #1;
    while (q.size() > 0)
    begin
      n = q.pop_front();
      case (n.k)
        0: obs = 16'(mode_o);
        1: obs = 16'(drive_o.sink_on);
        2: obs = 16'(drive_o.sink_divisor);
        3: obs = drive_o.boost_limit_ma;
        4: obs = 16'(lockout_o);
        5: obs = 16'(fault_latched_o);
        6: obs = 16'(ovp_flag_o);
        7: obs = 16'(supply_ok_o);
        8: obs = 16'(drive_o.boost_on);
        10: obs = 16'(drive_o.loop_member);
        default: obs = 16'(drive_o.comp_float);
      endcase
      comparisons++;
      if (obs !== n.v)
      begin
        fails++;
        $display("Error at %0t: kind %0d got %h want %h", $time, n.k, obs, n.v);
      end
    end
  end

  // Bounded wait for a mode, then time for the drive word to follow.
  task automatic wait_mode(input mode_e m);
    for (int i = 0; i < 40 && mode_o !== m; i++) @(negedge clk_i);
    note_v(0, 16'(m));
    repeat (2) @(negedge clk_i);
  endtask

  task automatic run_up();
    host.level(1'b1, 0);
    wait_mode(ST_RUN);
  endtask

  task automatic shut();
    host.level(1'b0, 20);
    note_v(0, 16'(ST_SHUTDOWN));
    note_v(5, 16'h0000);
    note_v(4, 16'h0000);
  endtask

  task automatic close_out();
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    close_out();
  end

  initial
  begin
    comp_i = '0;
    comp_i.supply_above_hys = 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    host.set(2'h3, 1'b0);
    host.level(1'b1, 0);
    wait_mode(ST_SOFT);
    note_v(3, SOFT_BOOST_LIMIT_MA);
    note_v(2, 16'(SOFT_SINK_DIVISOR));
    comp_i.sink_above_soft = 4'hf;
    wait_mode(ST_RUN);
    note_v(3, NORMAL_BOOST_LIMIT_MA);
    note_v(2, 16'(FULL_DIVISOR));
    note_v(8, 16'h0001);
    host.set(2'h3, 1'b1);
    repeat (3) @(negedge clk_i);
    note_v(2, 16'(QUARTER_DIVISOR));
    for (int i = 0; i < 4; i++)
    begin
      host.set(2'(i), 1'b0);
      repeat (3) @(negedge clk_i);
      note_v(1, 16'(mask[i]));
    end
    // One dimming pulse: off, then back on without losing the run state.
    host.level(1'b0, 4);
    note_v(8, 16'h0000);
    note_v(9, 16'h0001);
    note_v(1, 16'h0000);
    host.level(1'b1, 6);
    note_v(8, 16'h0001);
    note_v(1, 16'h000f);
    // Two overvoltage events with fresh regulation status each time.
    for (int r = 0; r < 2; r++)
    begin
      inreg = 4'($random(seed));
      comp_i.sink_in_reg = inreg;
      comp_i.ovp_high = 1'b1;
      repeat (6) @(negedge clk_i);
      note_v(6, 16'h0001);
      note_v(4, 16'(4'(~inreg)));
      note_v(10, 16'(inreg));
      note_v(1, 16'h000f);
      comp_i.ovp_high = 1'b0;
      repeat (6) @(negedge clk_i);
      note_v(6, 16'h0001);
      comp_i.ovp_low = 1'b1;
      repeat (6) @(negedge clk_i);
      note_v(6, 16'h0000);
      comp_i.ovp_low = 1'b0;
    end
    host.level(1'b0, 8);
    note_v(4, 16'(4'(~inreg)));
    host.level(1'b1, 4);
    shut();
    // Short on an unselected string, switch-node overvoltage, overcurrent.
    for (int f = 0; f < 3; f++)
    begin
      host.set(2'h0, 1'b0);
      run_up();
      comp_i.sink_short = (f == 0) ? 4'h8 : 4'h0;
      comp_i.switch_overvolt = (f == 1);
      comp_i.disconnect_overcurrent = (f == 2);
      repeat (6) @(negedge clk_i);
      comp_i.sink_short = 4'h0;
      comp_i.switch_overvolt = 1'b0;
      comp_i.disconnect_overcurrent = 1'b0;
      repeat (4) @(negedge clk_i);
      note_v(5, 16'h0001);
      note_v(0, 16'(ST_LATCHED));
      note_v(8, 16'h0000);
      shut();
    end
    // A short supply dip is filtered; a long one trips the lockout.
    run_up();
    comp_i.supply_above_hys = 1'b0;
    comp_i.supply_below_th = 1'b1;
    repeat (5) @(negedge clk_i);
    comp_i.supply_below_th = 1'b0;
    repeat (4) @(negedge clk_i);
    note_v(7, 16'h0001);
    comp_i.supply_below_th = 1'b1;
    repeat (14) @(negedge clk_i);
    note_v(7, 16'h0000);
    note_v(0, 16'(ST_SHUTDOWN));
    comp_i.supply_below_th = 1'b0;
    comp_i.supply_above_hys = 1'b1;
    repeat (6) @(negedge clk_i);
    note_v(7, 16'h0001);
    repeat (2) @(negedge clk_i);
    close_out();
  end
endmodule // led_string_driver_fault_control_tb
